// ---- logic/bsgm_pkg.sv ----
// Constants for the boot status and pin function register group
// Contract
// RQ1 - Status bit 1 flags failed integrity check
// RQ2 - Status bit 0 sets when load completes
// RQ3 - Status upper six bits read zero
// RQ4 - Software sets first coefficient marker bit
// RQ5 - Read-only supply code, volts times 8.428
// RQ6 - Direction bits: 0 input, 1 output
// RQ7 - Direction bits reset to input
// RQ8 - Code 0010 drives user output value
// RQ9 - Code 0011 drives both-channel auto-mute
// RQ10 - Codes 0100/0101 drive left/right auto-mute
// RQ11 - Code 0110 drives clock-invalid flag
// RQ12 - Code 1000 drives warning output
// RQ13 - Code 1001 drives serial audio output
// RQ14 - Code 1011 drives fault output
// RQ15 - Codes 1100/1101 drive master clock/data-out
// RQ16 - Load-start bit selects external memory fetch
// RQ17 - Reserved codes hold pin 0 low
// RQ18 - Pin 0 driven only when direction output
package bsgm_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] BSGM_OFS_BOOT_STATUS = 8'h5B;
   localparam logic [7:0] BSGM_OFS_FILT_WR     = 8'h5C;
   localparam logic [7:0] BSGM_OFS_SUPPLY      = 8'h5E;
   localparam logic [7:0] BSGM_OFS_DIR         = 8'h60;
   localparam logic [7:0] BSGM_OFS_PIN0_SEL    = 8'h61;
   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int         BSGM_BIT_DONE        = 0;
   localparam int         BSGM_BIT_CRC_ERR     = 1;
   localparam int         BSGM_BIT_FIRST_COEF  = 0;
   localparam logic [7:0] BSGM_RST_BYTE        = 8'h00;
   localparam logic [2:0] BSGM_RST_DIR         = 3'h0;
   localparam logic [3:0] BSGM_RST_SEL         = 4'h0;
   // ---------------------------------------------------------------
   // Pin 0 function codes
   // ---------------------------------------------------------------
   localparam logic [3:0] BSGM_SEL_USER        = 4'h2;
   localparam logic [3:0] BSGM_SEL_MUTE_BOTH   = 4'h3;
   localparam logic [3:0] BSGM_SEL_MUTE_LEFT   = 4'h4;
   localparam logic [3:0] BSGM_SEL_MUTE_RIGHT  = 4'h5;
   localparam logic [3:0] BSGM_SEL_CLK_INVALID = 4'h6;
   localparam logic [3:0] BSGM_SEL_WARN        = 4'h8;
   localparam logic [3:0] BSGM_SEL_AUDIO_OUT   = 4'h9;
   localparam logic [3:0] BSGM_SEL_FAULT       = 4'hB;
   localparam logic [3:0] BSGM_SEL_SPI_CLK     = 4'hC;
   localparam logic [3:0] BSGM_SEL_SPI_MOSI    = 4'hD;
endpackage : bsgm_pkg

// ---- logic/bsgm_pin0_mux.sv ----
// Pin 0 function multiplexer
`timescale 1ns/10ps
module bsgm_pin0_mux (
   // Selection
   input  wire logic [3:0] pin0_function_code,
   // Sources
   input  wire logic       user_out_value,
   input  wire logic       mute_left,
   input  wire logic       mute_right,
   input  wire logic       clock_invalid,
   input  wire logic       warning_out_n,
   input  wire logic       fault_out_n,
   input  wire logic       serial_audio_out,
   input  wire logic       spi_clk_out,
   input  wire logic       spi_mosi_out,
   // Result
   output logic            pin0_level
);
   always_comb begin
      unique case (pin0_function_code)
         bsgm_pkg::BSGM_SEL_USER:        pin0_level = user_out_value;            // RQ8
         bsgm_pkg::BSGM_SEL_MUTE_BOTH:   pin0_level = mute_left & mute_right;    // RQ9
         bsgm_pkg::BSGM_SEL_MUTE_LEFT:   pin0_level = mute_left;                 // RQ10
         bsgm_pkg::BSGM_SEL_MUTE_RIGHT:  pin0_level = mute_right;                // RQ10
         bsgm_pkg::BSGM_SEL_CLK_INVALID: pin0_level = clock_invalid;             // RQ11
         bsgm_pkg::BSGM_SEL_WARN:        pin0_level = warning_out_n;             // RQ12
         bsgm_pkg::BSGM_SEL_AUDIO_OUT:   pin0_level = serial_audio_out;          // RQ13
         bsgm_pkg::BSGM_SEL_FAULT:       pin0_level = fault_out_n;               // RQ14
         bsgm_pkg::BSGM_SEL_SPI_CLK:     pin0_level = spi_clk_out;               // RQ15
         bsgm_pkg::BSGM_SEL_SPI_MOSI:    pin0_level = spi_mosi_out;              // RQ15
         default:                        pin0_level = 1'b0;                      // RQ17
      endcase
   end
endmodule : bsgm_pin0_mux

// ---- logic/bsgm_regs.sv ----
// Boot status, supply code, pin direction and pin 0 function registers
`timescale 1ns/10ps
module bsgm_regs (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   // Register access port
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_write,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   // Boot load engine
   input  wire logic       load_done,
   input  wire logic       load_crc_error,
   output logic            load_from_memory,
   input  wire logic       load_from_memory_ctrl,
   // Filter write path
   output logic            first_coef_marker,
   // Supply converter
   input  wire logic [7:0] supply_voltage_code,
   // Pin 0 sources
   input  wire logic       user_out_value,
   input  wire logic       mute_left,
   input  wire logic       mute_right,
   input  wire logic       clock_invalid,
   input  wire logic       warning_out_n,
   input  wire logic       fault_out_n,
   input  wire logic       serial_audio_out,
   input  wire logic       spi_clk_out,
   input  wire logic       spi_mosi_out,
   // Pads
   output logic            io_pin_0_out,
   output logic            pin0_drive_enable,
   output logic            pin1_drive_enable,
   output logic            pin2_drive_enable
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic       done_reg,   done_next;
   logic       crc_reg,    crc_next;
   logic       first_reg,  first_next;
   logic [7:0] supply_reg, supply_next;
   logic [2:0] dir_reg,    dir_next;
   logic [3:0] sel_reg,    sel_next;
   logic       ext_reg,    ext_next;
   logic       pin0_reg,   pin0_next;
   logic [7:0] rdata_reg,  rdata_next;
   logic       pin0_level;

   // ---------------------------------------------------------------
   // Write decode and status capture
   // ---------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   always_comb begin
      ext_next    = load_from_memory_ctrl;                                  // RQ16
      done_next   = ext_reg & (done_reg | load_done);                       // RQ2 RQ16
      crc_next    = ext_reg & (load_done ? load_crc_error : crc_reg);       // RQ1
      supply_next = supply_voltage_code;                                    // RQ5
      first_next  = first_reg;
      dir_next    = dir_reg;
      sel_next    = sel_reg;
      if (reg_write && hit(reg_addr, bsgm_pkg::BSGM_OFS_FILT_WR)) begin
         first_next = reg_wdata[bsgm_pkg::BSGM_BIT_FIRST_COEF];             // RQ4
      end
      if (reg_write && hit(reg_addr, bsgm_pkg::BSGM_OFS_DIR)) begin
         dir_next = reg_wdata[2:0];                                         // RQ6
      end
      if (reg_write && hit(reg_addr, bsgm_pkg::BSGM_OFS_PIN0_SEL)) begin
         sel_next = reg_wdata[3:0];
      end
   end

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   always_comb begin
      rdata_next = bsgm_pkg::BSGM_RST_BYTE;
      if (hit(reg_addr, bsgm_pkg::BSGM_OFS_BOOT_STATUS)) begin
         rdata_next = {6'h00, crc_reg, done_reg};                           // RQ3
      end else if (hit(reg_addr, bsgm_pkg::BSGM_OFS_FILT_WR)) begin
         rdata_next = {7'h00, first_reg};
      end else if (hit(reg_addr, bsgm_pkg::BSGM_OFS_SUPPLY)) begin
         rdata_next = supply_reg;
      end else if (hit(reg_addr, bsgm_pkg::BSGM_OFS_DIR)) begin
         rdata_next = {5'h00, dir_reg};
      end else if (hit(reg_addr, bsgm_pkg::BSGM_OFS_PIN0_SEL)) begin
         rdata_next = {4'h0, sel_reg};
      end
   end

   // ---------------------------------------------------------------
   // Pin 0
   // ---------------------------------------------------------------
   bsgm_pin0_mux u_mux (
      .pin0_function_code (sel_reg),
      .user_out_value     (user_out_value),
      .mute_left          (mute_left),
      .mute_right         (mute_right),
      .clock_invalid      (clock_invalid),
      .warning_out_n      (warning_out_n),
      .fault_out_n        (fault_out_n),
      .serial_audio_out   (serial_audio_out),
      .spi_clk_out        (spi_clk_out),
      .spi_mosi_out       (spi_mosi_out),
      .pin0_level         (pin0_level)
   );

   always_comb begin
      pin0_next = pin0_level;
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         done_reg   <= 1'b0;
         crc_reg    <= 1'b0;
         first_reg  <= 1'b0;
         supply_reg <= bsgm_pkg::BSGM_RST_BYTE;
         dir_reg    <= bsgm_pkg::BSGM_RST_DIR;                              // RQ7
         sel_reg    <= bsgm_pkg::BSGM_RST_SEL;
         ext_reg    <= 1'b0;
         pin0_reg   <= 1'b0;
         rdata_reg  <= bsgm_pkg::BSGM_RST_BYTE;
      end else begin
         done_reg   <= done_next;
         crc_reg    <= crc_next;
         first_reg  <= first_next;
         supply_reg <= supply_next;
         dir_reg    <= dir_next;
         sel_reg    <= sel_next;
         ext_reg    <= ext_next;
         pin0_reg   <= pin0_next;
         rdata_reg  <= rdata_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign reg_rdata         = rdata_reg;
   assign first_coef_marker = first_reg;
   assign load_from_memory  = ext_reg;
   assign io_pin_0_out      = pin0_reg;
   assign pin0_drive_enable = dir_reg[0];                                   // RQ18
   assign pin1_drive_enable = dir_reg[1];
   assign pin2_drive_enable = dir_reg[2];
endmodule : bsgm_regs

// ---- bench/bsgm_regs_asserts.sv ----
// Concurrent checks on the register group ports
`timescale 1ns/10ps
module bsgm_regs_asserts (
   // Clock and reset
   input wire logic       clock,
   input wire logic       reset_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic       reg_write,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // Boot and supply
   input wire logic       load_done,
   input wire logic       load_crc_error,
   input wire logic       load_from_memory,
   input wire logic [7:0] supply_voltage_code,
   // Pin 0
   input wire logic       user_out_value,
   input wire logic       io_pin_0_out,
   input wire logic       pin0_drive_enable
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   logic [3:0] sel_reg;
   always_ff @(posedge clock or negedge reset_n)
      if (!reset_n) sel_reg <= 4'h0;
      else if (reg_write && reg_addr == 8'h61) sel_reg <= reg_wdata[3:0];
   sequence s_sup; $stable(supply_voltage_code) ##1 reg_addr == 8'h5E; endsequence
   sequence s_load; load_from_memory && load_done ##1 load_from_memory && reg_addr == 8'h5B; endsequence
   property p_rsvd; reg_addr == 8'h5B |=> reg_rdata[7:2] == 6'h00; endproperty
   a_rsvd: assert property (p_rsvd) else $error("status upper bits set");
   property p_sup; s_sup |=> reg_rdata == $past(supply_voltage_code, 2); endproperty
   a_sup: assert property (p_sup) else $error("supply code wrong");
   property p_dir; reg_write && reg_addr == 8'h60 |=> pin0_drive_enable == $past(reg_wdata[0]);
   endproperty
   a_dir: assert property (p_dir) else $error("direction not taken");
   property p_done; s_load |=> reg_rdata[0]; endproperty
   a_done: assert property (p_done) else $error("done bit not set");
   property p_crc; s_load |=> reg_rdata[1] == $past(load_crc_error, 2); endproperty
   a_crc: assert property (p_crc) else $error("integrity bit wrong");
   property p_clr; !load_from_memory ##1 reg_addr == 8'h5B && !load_from_memory
      |=> reg_rdata[1:0] == 2'h0; endproperty
   a_clr: assert property (p_clr) else $error("boot bits set without fetch");
   property p_user; pin0_drive_enable && sel_reg == 4'h2 |=> io_pin_0_out == $past(user_out_value);
   endproperty
   a_user: assert property (p_user) else $error("user level not on pin 0");
   property p_off; sel_reg inside {4'h0, 4'h1, 4'h7, 4'hA, 4'hE, 4'hF} |=> !io_pin_0_out;
   endproperty
   a_off: assert property (p_off) else $error("pin 0 not low");
endmodule : bsgm_regs_asserts
bind bsgm_regs bsgm_regs_asserts u_asserts (.*);

// ---- bench/test_boot_status_gpio_mux_regs.sv ----
// Self-checking bench for the register group
`timescale 1ns/10ps
module test_boot_status_gpio_mux_regs;
   logic       clock = 0, reset_n = 0, reg_write = 0, load_done = 0, load_crc_error = 0;
   logic       load_from_memory_ctrl = 0, user_out_value = 0, mute_left = 0, mute_right = 0;
   logic       clock_invalid = 0, warning_out_n = 0, fault_out_n = 0, serial_audio_out = 0;
   logic       spi_clk_out = 0, spi_mosi_out = 0, load_from_memory, first_coef_marker;
   logic       io_pin_0_out, pin0_drive_enable, pin1_drive_enable, pin2_drive_enable;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, supply_voltage_code = 8'h00, reg_rdata;
   int         n_errors = 0, num_checks = 0, cycles = 0;
   bsgm_regs DUT (.*);
   always #4 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles > 5000) begin
         n_errors++;
         conclude();
      end
   end
   task automatic conclude();
      if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1 {reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
      @(posedge clock);
      #1 reg_write = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clock);
      #1 reg_addr = a;
      @(posedge clock);
      #1 chk(what, exp, reg_rdata);
   endtask : rd
   function automatic logic pin_exp(input logic [3:0] c, input logic [8:0] s);
      case (c)
         4'h2: return s[0];
         4'h3: return s[1] & s[2];
         4'h4: return s[1];
         4'h5: return s[2];
         4'h6: return s[3];
         4'h8: return s[4];
         4'h9: return s[5];
         4'hB: return s[6];
         4'hC: return s[7];
         4'hD: return s[8];
         default: return 1'b0;
      endcase
   endfunction : pin_exp
   task automatic t_regs();
      rd(8'h60, 8'h00, "direction");
      rd(8'h5D, 8'h00, "unmapped");
      wr(8'h60, 8'hFA);
      rd(8'h60, 8'h02, "direction");
      chk("enables", 8'h02, {pin2_drive_enable, pin1_drive_enable, pin0_drive_enable});
      wr(8'h60, 8'h05);
      chk("enables", 8'h05, {pin2_drive_enable, pin1_drive_enable, pin0_drive_enable});
      wr(8'h5C, 8'hFF);
      rd(8'h5C, 8'h01, "filter ctrl");
      chk("marker", 8'h01, {7'h00, first_coef_marker});
      wr(8'h5B, 8'hFF);
      rd(8'h5B, 8'h00, "boot status");
   endtask : t_regs
   task automatic t_boot();
      load_from_memory_ctrl = 1'b1;
      rd(8'h5B, 8'h00, "boot status");
      chk("fetch select", 8'h01, {7'h00, load_from_memory});
      {load_done, load_crc_error} = 2'b11;
      @(posedge clock);
      #1 {load_done, load_crc_error} = 2'b00;
      rd(8'h5B, 8'h03, "boot status");
      load_done = 1'b1;
      @(posedge clock);
      #1 load_done = 1'b0;
      rd(8'h5B, 8'h01, "boot status");
      load_from_memory_ctrl = 1'b0;
      repeat (2) @(posedge clock);
      rd(8'h5B, 8'h00, "boot status");
   endtask : t_boot
   task automatic t_supply();
      supply_voltage_code = 8'hDF;
      rd(8'h5E, 8'hDF, "supply code");
      wr(8'h5E, 8'h00);
      supply_voltage_code = 8'h25;
      rd(8'h5E, 8'h25, "supply code");
   endtask : t_supply
   task automatic t_mux();
      logic [8:0] p [6] = '{9'h1FF, 9'h155, 9'h0AA, 9'h066, 9'h078, 9'h180};
      for (int c = 0; c < 16; c++) begin
         wr(8'h61, {4'hA, 4'(c)});
         rd(8'h61, {4'h0, 4'(c)}, "pin 0 code");
         for (int k = 0; k < 6; k++) begin
            {spi_mosi_out, spi_clk_out, fault_out_n, serial_audio_out, warning_out_n,
               clock_invalid, mute_right, mute_left, user_out_value} = p[k];
            @(posedge clock);
            #1 chk("pin 0", {7'h00, pin_exp(4'(c), p[k])}, {7'h00, io_pin_0_out});
         end
      end
   endtask : t_mux
   initial begin
      repeat (8) @(posedge clock);
      #1 reset_n = 1'b1;
      t_regs();
      t_boot();
      t_supply();
      t_mux();
      conclude();
   end
endmodule : test_boot_status_gpio_mux_regs
